//--- core/pmc_consts.svh
// Constants for the clock-mode and power-down control block.
// Assumes a 20 MHz system clock; included by the core.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// Power-down field position in the control/status word
`define PMC_PD_LSB        10
`define PMC_PD_MSB        15
// Power-down field codes
`define PMC_PD_NONE       6'h00
`define PMC_PD_LIGHT_EN   6'h09
`define PMC_PD_LIGHT_ANY  6'h11
`define PMC_PD_OUT_HALT   6'h1a
`define PMC_PD_IN_STOP    6'h1c
// Global interrupt enable bit in the control/status word
`define PMC_GIE_BIT       0
// Entry delay after the field write, in clocks
`define PMC_ENTRY_CYC     9
// Strap codes
`define PMC_STRAP_BYPASS  2'h0
`define PMC_STRAP_X6      2'h1
`define PMC_STRAP_X12     2'h2
`define PMC_STRAP_X20     2'h3
// Multiply factors
`define PMC_MUL_X1        5'h01
`define PMC_MUL_X6        5'h06
`define PMC_MUL_X12       5'h0c
`define PMC_MUL_X20       5'h14
// Lock time: typical in microseconds, worst case adds 150 percent
`define PMC_LOCK_TYP_US   75
`define PMC_LOCK_PCT      250
`define PMC_CLK_MHZ       20
// Auxiliary divide ratios
`define PMC_DIV_A         4
`define PMC_DIV_B         6

`endif

//--- core/pmc_pkg.sv
// Types for the clock-mode and power-down control block.
// Assumes pmc_consts.svh sits beside it.
package pmc_pkg;
	// Power-down state
	typedef enum logic [2:0] {
		PMC_RUN,
		PMC_ENTRY,
		PMC_LIGHT,
		PMC_OUT_HALT,
		PMC_IN_STOP
	} pmc_state_e;

	// Wake request from the interrupt logic
	typedef struct packed {
		logic irq_any;   // Any interrupt pending
		logic irq_en;    // An enabled interrupt pending
		logic nonmaskable_irq_enable;      // Non-maskable enable bit
	} pmc_wake_s;

	// Core control outputs
	typedef struct packed {
		logic core_clk_en;  // Core clock gate
		logic xfer_clk_en;  // Transfer engine clock gate
		logic pll_out_en;   // PLL output enable
		logic pll_in_en;    // PLL input enable
		logic io_freeze;    // Hold functional outputs
		logic run_isr;      // Take the service routine on wake
		logic resume;       // One-cycle resume pulse
	} pmc_ctrl_s;
endpackage

//--- core/pmc_core.sv
// Clock-mode decode, lock timing, divided clocks and power-down control.
// Assumes the processor writes the control/status word through wr_i and
// that the device reset arrives on rstn_i after power and the PLL settle.
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_core #(
	parameter int LOCK_CYC = (`PMC_LOCK_TYP_US * `PMC_CLK_MHZ * `PMC_LOCK_PCT) / 100
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	// Strap pins, asynchronous
	input  wire logic [1:0]        pll_factor_straps_i,
	// Control/status register port
	input  wire logic              wr_i,
	input  wire logic [31:0]       wdata_i,
	output logic      [31:0]       processor_control_status_o,
	// Interrupt logic wake requests
	input  wire pmc_pkg::pmc_wake_s wake_i,
	// Clock outputs and status
	output logic      [4:0]        pll_mult_o,
	output logic                   pll_locked_o,
	output logic                   core_div4_clock_out_o,
	output logic                   core_div6_clock_out_o,
	output pmc_pkg::pmc_ctrl_s     ctrl_o
);
	import pmc_pkg::*;

	//--------------------------------------------
	// Strap capture
	//--------------------------------------------
	logic [1:0]  strap_m_r;     // First stage, read only by second
	logic [1:0]  strap_s_r;     // Second stage
	logic [1:0]  strap_vld_r;   // Fill marker for the two sync stages
	logic        strap_done_r;  // Straps latched once after reset
	logic [1:0]  strap_r;       // Latched strap code

	// Pins are async, so two flops before use
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_m_r <= `PMC_STRAP_BYPASS;  // Pull-down default
			strap_s_r <= `PMC_STRAP_BYPASS;
		end else begin
			strap_m_r <= pll_factor_straps_i;
			strap_s_r <= strap_m_r;
		end
	end

	// Latch only once both stages hold pin values, else the reset code is taken
	// Later strap motion is ignored until the next reset
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_vld_r  <= 2'h0;
			strap_done_r <= 1'b0;
			strap_r      <= `PMC_STRAP_BYPASS;
		end else begin
			strap_vld_r <= {strap_vld_r[0], 1'b1};
			if (strap_vld_r[1] && !strap_done_r) begin
				strap_done_r <= 1'b1;
				strap_r      <= strap_s_r;
			end
		end
	end

	//--------------------------------------------
	// Multiply decode and lock timing
	//--------------------------------------------
	wire [4:0] mult_w = (strap_r == `PMC_STRAP_X6)  ? `PMC_MUL_X6  :
	                    (strap_r == `PMC_STRAP_X12) ? `PMC_MUL_X12 :
	                    (strap_r == `PMC_STRAP_X20) ? `PMC_MUL_X20 :
	                    `PMC_MUL_X1;
	wire       bypass_w = (strap_r == `PMC_STRAP_BYPASS);

	logic [31:0] lock_cnt_r;  // Cycles waited for lock
	logic        locked_r;    // Core clock usable
	wire         lock_hit_w = (lock_cnt_r >= 32'(LOCK_CYC));

	// Bypass needs no lock; multiply waits worst case
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lock_cnt_r <= 32'h0;
			locked_r   <= 1'b0;
		end else if (strap_done_r && !locked_r) begin
			if (bypass_w || lock_hit_w) begin
				locked_r <= 1'b1;  // relock after each reset
			end else begin
				lock_cnt_r <= lock_cnt_r + 32'h1;
			end
		end
	end

	//--------------------------------------------
	// Auxiliary divided clocks
	//--------------------------------------------
	logic [2:0] div_a_r;  // Divide-by-four phase
	logic [2:0] div_b_r;  // Divide-by-six phase
	logic       clk_a_r;
	logic       clk_b_r;
	pmc_ctrl_s  ctrl_nxt_w;  // Next control word; dividers follow its PLL gate
	wire        a_wrap_w = (div_a_r == 3'(`PMC_DIV_A / 2 - 1));
	wire        b_wrap_w = (div_b_r == 3'(`PMC_DIV_B / 2 - 1));

	// Toggle at half period; runs in every strap mode
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_a_r <= 3'h0;
			div_b_r <= 3'h0;
			clk_a_r <= 1'b0;
			clk_b_r <= 1'b0;
		end else if (ctrl_nxt_w.pll_out_en) begin
			div_a_r <= a_wrap_w ? 3'h0 : div_a_r + 3'h1;
			div_b_r <= b_wrap_w ? 3'h0 : div_b_r + 3'h1;
			clk_a_r <= a_wrap_w ? ~clk_a_r : clk_a_r;
			clk_b_r <= b_wrap_w ? ~clk_b_r : clk_b_r;
		end
	end

	//--------------------------------------------
	// Control/status word and power-down sequencer
	//--------------------------------------------
	logic [31:0] csr_r;     // Stored control/status word
	pmc_state_e  state_r;   // Power-down state
	logic [3:0]  entry_r;   // Entry delay count
	logic [5:0]  mode_r;    // Code captured at write
	logic        resume_r;  // Resume pulse
	logic        isr_r;     // Service routine request

	wire [5:0] pd_wr_w  = wdata_i[`PMC_PD_MSB:`PMC_PD_LSB];
	wire       pd_ok_w  = (pd_wr_w == `PMC_PD_LIGHT_EN) || (pd_wr_w == `PMC_PD_LIGHT_ANY) ||
	                      (pd_wr_w == `PMC_PD_OUT_HALT) || (pd_wr_w == `PMC_PD_IN_STOP);
	wire       in_run_w = (state_r == PMC_RUN);
	wire       entry_done_w = (entry_r == 4'(`PMC_ENTRY_CYC - 1));
	// Light wake: code 01_0001 takes any interrupt, 00_1001 enabled only
	wire       wake_w   = (mode_r == `PMC_PD_LIGHT_ANY) ? wake_i.irq_any : wake_i.irq_en;
	wire       isr_ok_w = wake_i.irq_en && csr_r[`PMC_GIE_BIT] && wake_i.nonmaskable_irq_enable;

	// Writes only land while running; reserved codes act as no power-down
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csr_r <= 32'h0;
		end else if (wr_i && in_run_w) begin
			csr_r <= wdata_i;  // Whole field in one write
		end else if (state_r == PMC_LIGHT && wake_w) begin
			csr_r[`PMC_PD_MSB:`PMC_PD_LSB] <= `PMC_PD_NONE;  // Field clears on wake
		end
	end

	// Sequencer; deep states exit only through rstn_i
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r  <= PMC_RUN;
			entry_r  <= 4'h0;
			mode_r   <= `PMC_PD_NONE;
			resume_r <= 1'b0;
			isr_r    <= 1'b0;
		end else begin
			resume_r <= 1'b0;
			case (state_r)
				PMC_RUN: begin
					if (wr_i && pd_ok_w) begin
						state_r <= PMC_ENTRY;
						mode_r  <= pd_wr_w;
						entry_r <= 4'h0;
					end
				end
				PMC_ENTRY: begin
					entry_r <= entry_r + 4'h1;
					if (entry_done_w) begin
						if (mode_r == `PMC_PD_OUT_HALT) begin
							state_r <= PMC_OUT_HALT;
						end else if (mode_r == `PMC_PD_IN_STOP) begin
							state_r <= PMC_IN_STOP;
						end else begin
							state_r <= PMC_LIGHT;
						end
					end
				end
				PMC_LIGHT: begin
					if (wake_w) begin
						state_r  <= PMC_RUN;
						resume_r <= 1'b1;
						isr_r    <= isr_ok_w;
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	//--------------------------------------------
	// Gate decode
	//--------------------------------------------
	wire deep_w = (state_r == PMC_OUT_HALT) || (state_r == PMC_IN_STOP);
	assign ctrl_nxt_w.core_clk_en = locked_r && in_run_w || locked_r && state_r == PMC_ENTRY;
	assign ctrl_nxt_w.xfer_clk_en = locked_r && !deep_w;
	assign ctrl_nxt_w.pll_out_en  = !deep_w;
	assign ctrl_nxt_w.pll_in_en   = (state_r != PMC_IN_STOP);
	assign ctrl_nxt_w.io_freeze   = deep_w;
	assign ctrl_nxt_w.run_isr     = isr_r;
	assign ctrl_nxt_w.resume      = resume_r;

	//--------------------------------------------
	// Registered outputs
	//--------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			processor_control_status_o <= 32'h0;
			pll_mult_o                 <= `PMC_MUL_X1;
			pll_locked_o               <= 1'b0;
			core_div4_clock_out_o      <= 1'b0;
			core_div6_clock_out_o      <= 1'b0;
			ctrl_o                     <= '0;
		end else begin
			processor_control_status_o <= csr_r;
			pll_mult_o                 <= mult_w;
			pll_locked_o               <= locked_r;
			core_div4_clock_out_o      <= clk_a_r;
			core_div6_clock_out_o      <= clk_b_r;
			ctrl_o                     <= ctrl_nxt_w;
		end
	end
endmodule

//--- dv/pmc_core_asserts.sv
// Checker for pmc_core, watching only its ports.
// Assumes straps stay put between resets and writes land only in run state.
`timescale 1ns/10ps
module pmc_core_asserts #(
	parameter int LOCK_CYC = 10
) (
	// Clock and reset
	input wire logic               sys_clk_i,
	input wire logic               rstn_i,
	// Inputs
	input wire logic [1:0]         pll_factor_straps_i,
	input wire logic               wr_i,
	input wire logic [31:0]        wdata_i,
	input wire pmc_pkg::pmc_wake_s wake_i,
	// Outputs
	input wire logic [31:0]        processor_control_status_o,
	input wire logic [4:0]         pll_mult_o,
	input wire logic               pll_locked_o,
	input wire logic               core_div4_clock_out_o,
	input wire logic               core_div6_clock_out_o,
	input wire pmc_pkg::pmc_ctrl_s ctrl_o
);
	import pmc_pkg::*;
	int      cnt_r;   // Edges since reset release, saturating
	logic [4:0] mul_exp; // Factor the straps ask for
	wire [5:0]  fld = wdata_i[15:10];
	// Resume cycle excluded: the field was cleared on the edge before it
	wire        run_wr = wr_i && ctrl_o.core_clk_en && !ctrl_o.resume;
	assign mul_exp = pll_factor_straps_i == 2'h0 ? 5'h01 : pll_factor_straps_i == 2'h1 ? 5'h06 :
		pll_factor_straps_i == 2'h2 ? 5'h0c : 5'h14;
	// Counter lets lock time be judged without long repeats
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cnt_r <= 0;
		else if (cnt_r < 99999)
			cnt_r <= cnt_r + 1;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	a_mult_decode: assert property (pll_locked_o |-> pll_mult_o == mul_exp)
		else $error("multiply factor does not match straps");
	a_lock_time: assert property ($rose(pll_locked_o) |->
		(pll_mult_o == 5'h01 ? cnt_r <= 6 : cnt_r >= LOCK_CYC)) else $error("lock wait wrong");
	a_div4_period: assert property ($rose(core_div4_clock_out_o) |->
		##4 ($rose(core_div4_clock_out_o) || ctrl_o.io_freeze)) else $error("div4 period wrong");
	a_div6_period: assert property ($rose(core_div6_clock_out_o) |->
		##6 ($rose(core_div6_clock_out_o) || ctrl_o.io_freeze)) else $error("div6 period wrong");
	a_light_entry: assert property (run_wr && (fld == 6'h09 || fld == 6'h11) |->
		##11 (!ctrl_o.core_clk_en && ctrl_o.xfer_clk_en && !ctrl_o.io_freeze)) else $error("light entry wrong");
	a_halt_entry: assert property (run_wr && fld == 6'h1a |->
		##11 (ctrl_o.io_freeze && !ctrl_o.pll_out_en)) else $error("output halt entry wrong");
	a_stop_entry: assert property (run_wr && fld == 6'h1c |->
		##11 (ctrl_o.io_freeze && !ctrl_o.pll_in_en)) else $error("input stop entry wrong");
	a_deep_stick: assert property (ctrl_o.io_freeze |=> ctrl_o.io_freeze && !ctrl_o.core_clk_en)
		else $error("deep mode left without reset");
	a_wake_resume: assert property ($rose(wake_i.irq_en) && !ctrl_o.core_clk_en && !ctrl_o.io_freeze |->
		##2 (ctrl_o.resume && ctrl_o.core_clk_en)) else $error("no resume on wake");
	a_isr_gate: assert property ($rose(ctrl_o.resume) |-> ctrl_o.run_isr == ($past(wake_i.irq_en, 2) &&
		$past(wake_i.nonmaskable_irq_enable, 2) && $past(processor_control_status_o[0], 2))) else $error("service flag wrong");
	a_status_write: assert property (run_wr |-> ##2 {processor_control_status_o[15:10],
		processor_control_status_o[0]} == {$past(fld, 2), $past(wdata_i[0], 2)}) else $error("word not stored");
	c_light: cover property (ctrl_o.resume);
	c_freeze: cover property ($rose(ctrl_o.io_freeze));
	c_lock: cover property ($rose(pll_locked_o) && pll_mult_o == 5'h14);
endmodule
bind pmc_core pmc_core_asserts #(.LOCK_CYC(LOCK_CYC)) u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.pll_factor_straps_i(pll_factor_straps_i), .wr_i(wr_i), .wdata_i(wdata_i), .wake_i(wake_i),
	.processor_control_status_o(processor_control_status_o), .pll_mult_o(pll_mult_o),
	.pll_locked_o(pll_locked_o), .core_div4_clock_out_o(core_div4_clock_out_o),
	.core_div6_clock_out_o(core_div6_clock_out_o), .ctrl_o(ctrl_o));

//--- dv/pmc_board.sv
// Board model: strap resistors and the reset driver.
// Assumes the bench asks for reset until it judges the clock settled.
`timescale 1ns/10ps
module pmc_board (
	input  wire logic       drv_i,     // Forces both straps low when high; kept low
	input  wire logic [1:0] pull_i,    // Pull-ups fitted per strap
	input  wire logic       rst_req_i, // Reset wanted
	output logic [1:0]      straps_o,
	output logic            rstn_o
);
	// Unfitted straps fall to the internal pull-down level
	assign straps_o = pull_i & {2{~drv_i}};
	// Reset stays low for as long as asked, covering PLL settling
	assign rstn_o = ~rst_req_i;
endmodule

//--- dv/tb_pmc_core.sv
// Bench for pmc_core: strap decode, light and deep power-down.
// Assumes pmc_board supplies straps and reset; checker is bound in.
`timescale 1ns/10ps
module tb_pmc_core;
	import pmc_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_req, wr, rstn, lock, d4, d6;
	logic [1:0] pull, straps;
	logic [31:0] wd, stat;
	logic [4:0] mult;
	pmc_wake_s  wake;
	pmc_ctrl_s  ctrl;
	int         num_errors = 0;
	int         tests_run = 0;
	int         cyc = 0;
	always #25 sys_clk = ~sys_clk;
	pmc_board u_brd (.drv_i(1'b0), .pull_i(pull), .rst_req_i(rst_req), .straps_o(straps), .rstn_o(rstn));
	pmc_core #(.LOCK_CYC(10)) u_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .pll_factor_straps_i(straps),
		.wr_i(wr), .wdata_i(wd), .processor_control_status_o(stat), .wake_i(wake), .pll_mult_o(mult),
		.pll_locked_o(lock), .core_div4_clock_out_o(d4), .core_div6_clock_out_o(d6), .ctrl_o(ctrl));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Six-cycle reset, then a bounded wait for lock
	task automatic do_reset(logic [1:0] p);
		@(negedge sys_clk);
		pull = p;
		rst_req = 1'b1;
		repeat (6) @(negedge sys_clk);
		rst_req = 1'b0;
		for (int i = 0; i < 60 && lock !== 1'b1; i++) @(negedge sys_clk);
	endtask
	task automatic wr_word(logic [31:0] v);
		@(negedge sys_clk);
		wd = v;
		wr = 1'b1;
		@(negedge sys_clk);
		wr = 1'b0;
	endtask
	task automatic t_straps;
		logic [4:0] tbl [4] = '{5'h01, 5'h06, 5'h0c, 5'h14};
		for (int s = 3; s >= 0; s--) begin
			do_reset(2'(s));
			chk("mult", 32'(tbl[s]), 32'(mult));
			chk("locked", 32'h1, 32'(lock));
		end
		$display("test straps done");
	endtask
	task automatic t_light(logic [5:0] c, logic g, logic e, logic m);
		wr_word({16'h0, c, 9'h0, g});
		repeat (12) @(negedge sys_clk);
		chk("core_gated", 32'h0, 32'(ctrl.core_clk_en));
		chk("xfer_runs", 32'h1, 32'(ctrl.xfer_clk_en));
		if (c == 6'h09) begin
			wake = '{1'b1, 1'b0, m};
			repeat (4) @(negedge sys_clk);
			chk("any_no_wake", 32'h0, 32'(ctrl.core_clk_en));
		end
		wake = '{1'b1, e, m};
		for (int i = 0; i < 8 && ctrl.resume !== 1'b1; i++) @(negedge sys_clk);
		chk("resume", 32'h1, 32'(ctrl.resume));
		chk("run_isr", 32'(e & g & m), 32'(ctrl.run_isr));
		wake = '0;
		repeat (3) @(negedge sys_clk);
		$display("test light %h done", c);
	endtask
	task automatic t_resv;
		wr_word({16'h0, 6'h01, 10'h0});
		repeat (12) @(negedge sys_clk);
		chk("resv_runs", 32'h1, 32'(ctrl.core_clk_en));
		chk("field", 32'h01, 32'(stat[15:10]));
		$display("test reserved done");
	endtask
	task automatic t_deep(logic [5:0] c);
		wr_word({16'h0, c, 10'h0});
		repeat (12) @(negedge sys_clk);
		chk("freeze", 32'h1, 32'(ctrl.io_freeze));
		chk("pll_gate", 32'h0, 32'(c == 6'h1a ? ctrl.pll_out_en : ctrl.pll_in_en));
		wake = '{1'b1, 1'b1, 1'b1};
		repeat (6) @(negedge sys_clk);
		chk("still_frozen", 32'h1, 32'(ctrl.io_freeze));
		wake = '0;
		do_reset(2'h1);
		chk("relocked", 32'h1, 32'(lock));
		$display("test deep %h done", c);
	endtask
	// Hang guard: whole run is well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		rst_req = 1'b1;
		pull = 2'h0;
		wr = 1'b0;
		wd = '0;
		wake = '0;
		t_straps();
		t_light(6'h09, 1'b1, 1'b1, 1'b1);
		t_light(6'h09, 1'b0, 1'b1, 1'b1);
		t_light(6'h11, 1'b1, 1'b0, 1'b1);
		t_light(6'h11, 1'b1, 1'b1, 1'b0);
		t_resv();
		t_deep(6'h1a);
		t_deep(6'h1c);
		finish_test();
	end
endmodule
